/* verilog/srp_pkg.sv */
// Package of register map, field layouts and constants for the SPI rate/pin block
package srp_pkg;

	// Register byte addresses
	localparam logic [3:0] ADDR_RATE   = 4'h0;
	localparam logic [3:0] ADDR_CTRL   = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;

	// Rate register fields
	localparam int RATE_SEL_LSB = 0;
	localparam int RATE_SEL_W   = 3;
	localparam int PRE_SEL_LSB  = 4;
	localparam int PRE_SEL_W    = 3;
	localparam logic [7:0] RATE_MASK  = 8'h77;
	localparam logic [7:0] RATE_RESET = 8'h00;

	// Control register fields
	localparam int CTRL_MODULE_ON  = 0;
	localparam int CTRL_CTRL_SEL   = 1;
	localparam int CTRL_SINGLE_PIN = 2;
	localparam int CTRL_SHARED_OE  = 3;
	localparam int CTRL_FAULT_EN   = 4;
	localparam int CTRL_SS_OUT_EN  = 5;
	localparam logic [7:0] CTRL_MASK  = 8'h3f;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Status register fields (fault flag cleared by writing one)
	localparam int STAT_FAULT  = 0;
	localparam int STAT_ACTIVE = 1;

	// Transfer length and AXI response codes
	localparam logic [3:0] BITS_PER_FRAME = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sequencer states
	typedef enum logic [1:0] {SRP_IDLE, SRP_LEAD, SRP_TRAIL} srp_state_t;

endpackage : srp_pkg

/* verilog/srp_core.sv */
// SPI rate generator, pin direction control and mode fault detection
//
// Overview of operation
// - Serial clock is bus clock divided
// - Prescale zero gives divisors two to 256
// - Prescale one doubles the divisors
// - Master rate change aborts transfer to idle
// - Rate register always accessible, reserved ignored
// - Controller select picks master or slave
// - Normal mode: master out MOSI, in MISO
// - Shared pin drives only with drive enable
// - Shared pin both drives and samples data
// - Bidirectional master uses MOSI only
// - Clock pin output as master, input slave
// - Select pin input slave, either as master
// - Clock and select unaffected by bidirectional mode
// - Mode fault is the only error
// - Low select as master sets fault flag unless select is an output
// - Fault detect off ignores select pin
// - Mode fault drops device into slave
// - Faulted bidirectional device uses MISO pin
`timescale 1ns/1ps
module srp_core (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// AXI4-Lite write address and data
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Transfer start from user logic
	input  wire logic        xfer_start,
	input  wire logic [7:0]  xfer_data,
	// Serial clock pin
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	// Data pins
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	// Slave select pin
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe,
	// Shift register input and state view
	output logic             serial_in,
	output logic             master_now
);

	// Divisor from prescale and rate fields
	function automatic logic [11:0] rate_divisor(input logic [7:0] r);
		logic [2:0] pre;
		logic [2:0] sel;
		pre = r[srp_pkg::PRE_SEL_LSB +: srp_pkg::PRE_SEL_W];
		sel = r[srp_pkg::RATE_SEL_LSB +: srp_pkg::RATE_SEL_W];
		rate_divisor = 12'({1'b0, pre} + 4'h1) << (4'(sel) + 4'h1);
	endfunction : rate_divisor

	logic [7:0]  rate_reg;
	logic [7:0]  ctrl_reg;
	logic        fault_flag;
	logic [1:0]  mosi_s, miso_s, sck_s, ss_s;
	logic        aw_got, w_got;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	srp_pkg::srp_state_t state;
	logic [11:0] div_cnt;
	logic [3:0]  bit_cnt;
	logic [7:0]  shreg;
	logic        sck_gen;

	wire logic module_on   = ctrl_reg[srp_pkg::CTRL_MODULE_ON];
	wire logic single_pin  = ctrl_reg[srp_pkg::CTRL_SINGLE_PIN];
	wire logic shared_oe   = ctrl_reg[srp_pkg::CTRL_SHARED_OE];
	wire logic fault_en    = ctrl_reg[srp_pkg::CTRL_FAULT_EN];
	wire logic ss_out_en   = ctrl_reg[srp_pkg::CTRL_SS_OUT_EN];
	// Master only while enabled, selected and not knocked out by a fault
	wire logic is_master   = module_on & ctrl_reg[srp_pkg::CTRL_CTRL_SEL];
	wire logic do_write    = aw_got & w_got & ~s_axi_bvalid;
	wire logic [11:0] half = rate_divisor(rate_reg) >> 1;

	// Second stage of the MOSI, MISO and select synchronisers, only stage logic reads
	wire logic mosi_q = mosi_s[1];
	wire logic miso_q = miso_s[1];
	wire logic ss_q   = ss_s[1];

	// Fault: select pin low while master with detection on and select output off
	wire logic fault_ev = is_master & fault_en & ~ss_out_en & ~ss_q;

	// Rate write that changes a field while master
	wire logic rate_wr = do_write && aw_addr == srp_pkg::ADDR_RATE && w_strb[0];
	wire logic rate_chg = rate_wr && is_master &&
		((w_data[7:0] & srp_pkg::RATE_MASK) != rate_reg);

	// Two-flop synchronisers for all pin inputs
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mosi_s <= 2'h0;
			miso_s <= 2'h0;
			sck_s  <= 2'h0;
			ss_s   <= 2'h3; // Idle high, so no false fault after reset
		end
		else
		begin
			mosi_s <= {mosi_s[0], mosi_i};
			miso_s <= {miso_s[0], miso_i};
			sck_s  <= {sck_s[0], sck_i};
			ss_s   <= {ss_s[0], ss_n_i};
		end
	end

	// AXI write channel: address and data taken in either order
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			aw_got <= 1'b0;
			w_got  <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= srp_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= ~aw_got & ~s_axi_awready;
			s_axi_wready  <= ~w_got & ~s_axi_wready;
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_got  <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == srp_pkg::ADDR_RATE ||
					aw_addr == srp_pkg::ADDR_CTRL ||
					aw_addr == srp_pkg::ADDR_STATUS) ?
					srp_pkg::RESP_OKAY : srp_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got <= 1'b0;
				w_got  <= 1'b0;
			end
		end
	end

	// Rate register: any time, reserved bits dropped
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rate_reg <= srp_pkg::RATE_RESET;
		else if (rate_wr)
			rate_reg <= w_data[7:0] & srp_pkg::RATE_MASK;
	end

	// Control register; a fault clears master select
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			ctrl_reg <= srp_pkg::CTRL_RESET;
		else
		begin
			if (do_write && aw_addr == srp_pkg::ADDR_CTRL && w_strb[0])
				ctrl_reg <= w_data[7:0] & srp_pkg::CTRL_MASK;
			if (fault_ev)
				ctrl_reg[srp_pkg::CTRL_CTRL_SEL] <= 1'b0;
		end
	end

	// Fault flag: set wins over write-one clear; held clear when disabled
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			fault_flag <= 1'b0;
		else if (fault_ev)
			fault_flag <= 1'b1;
		else if (~fault_en)
			fault_flag <= 1'b0;
		else if (do_write && aw_addr == srp_pkg::ADDR_STATUS &&
			w_strb[0] && w_data[srp_pkg::STAT_FAULT])
			fault_flag <= 1'b0;
	end

	// AXI read channel
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= srp_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= srp_pkg::RESP_OKAY;
				case (s_axi_araddr)
					srp_pkg::ADDR_RATE:   s_axi_rdata <= {24'h0, rate_reg};
					srp_pkg::ADDR_CTRL:   s_axi_rdata <= {24'h0, ctrl_reg};
					srp_pkg::ADDR_STATUS: s_axi_rdata <= {30'h0,
						state != srp_pkg::SRP_IDLE, fault_flag};
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= srp_pkg::RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Master bit sequencer; abort and fault both return it to idle
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= srp_pkg::SRP_IDLE;
			div_cnt <= 12'h0;
			bit_cnt <= 4'h0;
			shreg <= 8'h0;
			sck_gen <= 1'b0;
		end
		else if (rate_chg | fault_ev | ~is_master)
		begin
			state <= srp_pkg::SRP_IDLE;
			div_cnt <= 12'h0;
			bit_cnt <= 4'h0;
			sck_gen <= 1'b0;
		end
		else
		begin
			case (state)
				srp_pkg::SRP_IDLE:
					if (xfer_start)
					begin
						shreg <= xfer_data;
						bit_cnt <= 4'h0;
						div_cnt <= 12'h0;
						state <= srp_pkg::SRP_LEAD;
					end
				srp_pkg::SRP_LEAD:
					if (div_cnt == half - 12'h1)
					begin
						div_cnt <= 12'h0;
						sck_gen <= 1'b1;
						state <= srp_pkg::SRP_TRAIL;
					end
					else
						div_cnt <= div_cnt + 12'h1;
				srp_pkg::SRP_TRAIL:
					if (div_cnt == half - 12'h1)
					begin
						div_cnt <= 12'h0;
						sck_gen <= 1'b0;
						shreg <= {shreg[6:0], serial_in};
						bit_cnt <= bit_cnt + 4'h1;
						state <= (bit_cnt == srp_pkg::BITS_PER_FRAME - 4'h1) ?
							srp_pkg::SRP_IDLE : srp_pkg::SRP_LEAD;
					end
					else
						div_cnt <= div_cnt + 12'h1;
				default: state <= srp_pkg::SRP_IDLE;
			endcase
		end
	end

	// Pin directions and shift input, all registered
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sck_o <= 1'b0;
			sck_oe <= 1'b0;
			mosi_o <= 1'b0;
			mosi_oe <= 1'b0;
			miso_o <= 1'b0;
			miso_oe <= 1'b0;
			ss_n_o <= 1'b1;
			ss_n_oe <= 1'b0;
			serial_in <= 1'b0;
			master_now <= 1'b0;
		end
		else
		begin
			master_now <= is_master;
			sck_o <= sck_gen;
			sck_oe <= is_master;
			ss_n_o <= state == srp_pkg::SRP_IDLE;
			ss_n_oe <= is_master & ss_out_en;
			mosi_o <= shreg[7];
			miso_o <= shreg[7];
			if (~module_on)
			begin
				mosi_oe <= 1'b0;
				miso_oe <= 1'b0;
				serial_in <= 1'b0;
			end
			else if (~single_pin)
			begin
				mosi_oe <= is_master;
				miso_oe <= ~is_master;
				serial_in <= is_master ? miso_q : mosi_q;
			end
			else
			begin
				// One shared pin per role: MOSI master, MISO slave
				mosi_oe <= is_master & shared_oe;
				miso_oe <= ~is_master & shared_oe;
				serial_in <= is_master ? mosi_q : miso_q;
			end
		end
	end

	// Checks on the logic above
	property p_fault_set;
		@(posedge core_clk) disable iff (sys_rst)
		fault_ev |=> fault_flag && !is_master;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

	property p_fault_off;
		@(posedge core_clk) disable iff (sys_rst)
		!fault_en |=> !fault_flag;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("flag set while off");

	property p_to_slave;
		@(posedge core_clk) disable iff (sys_rst)
		fault_ev |=> !is_master ##1 !sck_oe;
	endproperty
	a_to_slave: assert property (p_to_slave) else $error("no slave switch");

	property p_abort;
		@(posedge core_clk) disable iff (sys_rst)
		rate_chg |=> state == srp_pkg::SRP_IDLE && bit_cnt == 4'h0;
	endproperty
	a_abort: assert property (p_abort) else $error("rate change no abort");

	property p_sck_dir;
		@(posedge core_clk) disable iff (sys_rst)
		1 |=> sck_oe == $past(is_master);
	endproperty
	a_sck_dir: assert property (p_sck_dir) else $error("sck direction");

	property p_bidir_pin;
		@(posedge core_clk) disable iff (sys_rst)
		module_on && single_pin && is_master |=> !miso_oe;
	endproperty
	a_bidir_pin: assert property (p_bidir_pin) else $error("miso used");

	property p_shared_oe;
		@(posedge core_clk) disable iff (sys_rst)
		module_on && single_pin && !shared_oe |=> !mosi_oe && !miso_oe;
	endproperty
	a_shared_oe: assert property (p_shared_oe) else $error("pin driven");

	property p_normal;
		@(posedge core_clk) disable iff (sys_rst)
		module_on && !single_pin |=> mosi_oe == $past(is_master);
	endproperty
	a_normal: assert property (p_normal) else $error("mosi direction");

	property p_rate_rw;
		@(posedge core_clk) disable iff (sys_rst)
		rate_wr |=> rate_reg == ($past(w_data[7:0]) & srp_pkg::RATE_MASK);
	endproperty
	a_rate_rw: assert property (p_rate_rw) else $error("rate write lost");

	c_xfer: cover property (@(posedge core_clk) state == srp_pkg::SRP_TRAIL
		&& bit_cnt == 4'h7);
	c_fault: cover property (@(posedge core_clk) fault_ev);
	c_abort: cover property (@(posedge core_clk) rate_chg
		&& state != srp_pkg::SRP_IDLE);

endmodule : srp_core

/* tb/srp_far_end.sv */
// Far-side SPI party: resolves each pin from both drivers
`timescale 1ns/1ps
module srp_far_end (
	// Pin drive from the block
	input  wire logic sck_o,
	input  wire logic sck_oe,
	input  wire logic mosi_o,
	input  wire logic mosi_oe,
	input  wire logic miso_o,
	input  wire logic miso_oe,
	input  wire logic ss_n_o,
	input  wire logic ss_n_oe,
	// Levels this party puts on lines it owns
	input  wire logic drv_lvl,
	input  wire logic ss_lvl,
	// Resolved pin levels back to the block
	output logic      sck_i,
	output logic      mosi_i,
	output logic      miso_i,
	output logic      ss_n_i
);
	// This party never runs frames, so its clock stands still low
	assign sck_i = sck_oe ? sck_o : 1'b0;
	// Opposite levels on the two data lines tell them apart at serial_in
	assign mosi_i = mosi_oe ? mosi_o : ~drv_lvl;
	assign miso_i = miso_oe ? miso_o : drv_lvl;
	// Select is pulled low only when a contention case is commanded
	assign ss_n_i = ss_n_oe ? ss_n_o : ss_lvl;
endmodule : srp_far_end

/* tb/tb.sv */
// Self-checking bench for the SPI rate, pin and fault block
`timescale 1ns/1ps
module tb;
	logic        core_clk = 1'b0;
	logic        sys_rst;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, xfer_start;
	logic [1:0]  bresp, rresp, rsp;
	logic [7:0]  xfer_data;
	logic        sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe;
	logic        miso_i, miso_o, miso_oe, ss_n_i, ss_n_o, ss_n_oe;
	logic        serial_in, master_now, lvl, ss_lvl, s;
	int          errors = 0;
	int          tests_run = 0;
	int          n;
	// Control value, {master_now,sck_oe,mosi_oe,miso_oe,ss_n_oe}, input
	logic [14:0] pin_tab [6] = '{{8'h03, 5'b11100, 2'd0},
		{8'h01, 5'b00010, 2'd1}, {8'h23, 5'b11101, 2'd0},
		{8'h27, 5'b11001, 2'd1}, {8'h0f, 5'b11100, 2'd2},
		{8'h00, 5'b00000, 2'd2}};

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	srp_core i_srp_core (.core_clk(core_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.xfer_start(xfer_start), .xfer_data(xfer_data),
		.sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i),
		.mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i),
		.miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n_i),
		.ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .serial_in(serial_in),
		.master_now(master_now));

	srp_far_end i_srp_far_end (.sck_o(sck_o), .sck_oe(sck_oe),
		.mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_o(miso_o),
		.miso_oe(miso_oe), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
		.drv_lvl(lvl), .ss_lvl(ss_lvl), .sck_i(sck_i), .mosi_i(mosi_i),
		.miso_i(miso_i), .ss_n_i(ss_n_i));

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Write on lane 0; both channels offered together, each held until taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge core_clk);
			if (awready === 1'b1)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge core_clk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd_reg(input logic [3:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : rd_reg

	task automatic results;
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	// Watchdog sized well above the longest divisor sweep
	initial
	begin
		#900us;
		errors++;
		results();
	end

	initial
	begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
		{arvalid, rready, xfer_start, xfer_data} = '0;
		wstrb = 4'h1;
		lvl = 1'b0;
		ss_lvl = 1'b1;
		sys_rst = 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		chk("oe_reset", {sck_oe, mosi_oe, miso_oe, ss_n_oe, ss_n_o}, 1);
		rd_reg(srp_pkg::ADDR_RATE);
		chk("rate_reset", rd, 32'h0);
		chk("rresp", rsp, srp_pkg::RESP_OKAY);
		wr(srp_pkg::ADDR_RATE, 32'hff);
		rd_reg(srp_pkg::ADDR_RATE);
		chk("rate_reserved", rd, 32'h77);
		wr(4'hc, 32'hff);
		chk("bresp_unmapped", rsp, srp_pkg::RESP_SLVERR);
		rd_reg(4'hc);
		chk("rresp_unmapped", rsp, srp_pkg::RESP_SLVERR);
		chk("rdata_unmapped", rd, 32'h0);
		// Each mode with both data levels, select held high
		for (int i = 0; i < 6; i++)
			for (int v = 0; v < 2; v++)
			begin
				lvl <= v[0];
				wr(srp_pkg::ADDR_CTRL, {24'h0, pin_tab[i][14:7]});
				repeat (6) @(posedge core_clk);
				chk("pins", {master_now, sck_oe, mosi_oe, miso_oe, ss_n_oe},
					pin_tab[i][6:2]);
				if (pin_tab[i][1:0] != 2'd2)
					chk("serial_in", serial_in, v[0] ^ pin_tab[i][0]);
			end
		// Select low but fault detection off: stays master, no flag
		ss_lvl <= 1'b0;
		wr(srp_pkg::ADDR_CTRL, 32'h03);
		repeat (8) @(posedge core_clk);
		chk("master_kept", master_now, 1);
		rd_reg(srp_pkg::ADDR_STATUS);
		chk("flag_off", rd[0], 0);
		wr(srp_pkg::ADDR_CTRL, 32'h13);
		repeat (8) @(posedge core_clk);
		chk("master_dropped", master_now, 0);
		rd_reg(srp_pkg::ADDR_STATUS);
		chk("flag_set", rd[0], 1);
		rd_reg(srp_pkg::ADDR_CTRL);
		chk("ctrl_after_fault", rd, 32'h11);
		ss_lvl <= 1'b1;
		wr(srp_pkg::ADDR_STATUS, 32'h1);
		rd_reg(srp_pkg::ADDR_STATUS);
		chk("flag_cleared", rd[0], 0);
		// Fault in bidirectional master moves the data pin to MISO
		wr(srp_pkg::ADDR_CTRL, 32'h1f);
		repeat (6) @(posedge core_clk);
		chk("bidir_master", {master_now, mosi_oe, miso_oe}, 3'b110);
		ss_lvl <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk("bidir_fault", {master_now, mosi_oe, miso_oe}, 3'b001);
		ss_lvl <= 1'b1;
		wr(srp_pkg::ADDR_CTRL, 32'h03);
		// Every divisor, then for divisors of 64 and above abort the frame by a rate change
		for (int p = 0; p < 8; p++)
			for (int r = 0; r < 8; r++)
			begin
				wr(srp_pkg::ADDR_RATE, {25'h0, p[2:0], 1'b0, r[2:0]});
				rd_reg(srp_pkg::ADDR_RATE);
				chk("rate_rw", rd, {25'h0, p[2:0], 1'b0, r[2:0]});
				xfer_start <= 1'b1;
				xfer_data <= 8'ha5;
				@(posedge core_clk);
				xfer_start <= 1'b0;
				s = sck_o;
				while (sck_o === s) @(posedge core_clk);
				chk("mosi_msb", mosi_o, 1);
				chk("ss_frame", ss_n_o, 0);
				s = sck_o;
				n = 0;
				while (sck_o === s)
				begin
					@(posedge core_clk);
					n++;
				end
				chk("half_period", n, ((p + 1) << (r + 1)) / 2);
				if (((p + 1) << (r + 1)) >= 64)
				begin
					rd_reg(srp_pkg::ADDR_STATUS);
					chk("active", rd[1], 1);
					wr(srp_pkg::ADDR_RATE, {25'h0, p[2:0], 1'b0, ~r[2:0]});
					rd_reg(srp_pkg::ADDR_STATUS);
					chk("aborted", rd[1], 0);
				end
			end
		results();
	end
endmodule : tb
